// *** iad_pkg.sv ***
// Constants for the integer add datapath: encodings, field positions, widths.
// Assumes 32-bit instruction words and 6-bit register indices (top half extension).
package iad_pkg;

  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IDX_W    = 6;
  localparam int unsigned IMM_W    = 12;
  localparam int unsigned TID_W    = 4;

  // Primary opcode field
  localparam int unsigned OPC_HI   = 31;
  localparam int unsigned OPC_LO   = 28;
  localparam logic [3:0]  OPC_RTYPE = 4'h3;
  localparam logic [3:0]  OPC_ITYPE = 4'h2;

  // Register-register form fields
  localparam int unsigned R_A_LO   = 20;
  localparam int unsigned R_B_LO   = 14;
  localparam int unsigned R_C_LO   = 8;
  localparam int unsigned R_FN_HI  = 5;
  localparam int unsigned R_FN_LO  = 0;
  localparam logic [5:0]  FN_ADD   = 6'h31;

  // Immediate form fields
  localparam int unsigned I_A_LO   = 22;
  localparam int unsigned I_B_LO   = 16;
  localparam int unsigned I_SUB_HI = 15;
  localparam int unsigned I_SUB_LO = 12;
  localparam logic [3:0]  SUB_ADDI = 4'h3;
  localparam int unsigned I_IMM_LO = 0;

  // Index bit that marks an extension register
  localparam int unsigned EXT_BIT  = 5;

  // Reset values
  localparam logic [31:0] RST_DATA = 32'h0000_0000;
  localparam logic [5:0]  RST_IDX  = 6'h00;

  typedef enum logic [1:0] {
    IAD_OP_NONE,
    IAD_OP_ADD,
    IAD_OP_ADDI,
    IAD_OP_BAD
  } iad_op_t;

endpackage

// *** iad_adder.sv ***
// Wrapping adder with optional sign extension of a short immediate.
// Purely combinational; the caller registers the result.
`timescale 1ns/100ps
module iad_adder #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned IMM_W = 12
) (
  // Operands
  input  wire logic [WIDTH-1:0] first_operand,
  input  wire logic [WIDTH-1:0] second_operand,
  input  wire logic [IMM_W-1:0] short_immediate,
  input  wire logic             use_immediate,
  // Result
  output logic      [WIDTH-1:0] sum
);

  logic [WIDTH-1:0] imm_ext;
  logic [WIDTH-1:0] addend;

  // Top immediate bit carries the sign
  assign imm_ext = {{(WIDTH-IMM_W){short_immediate[IMM_W-1]}}, short_immediate};
  assign addend  = use_immediate ? imm_ext : second_operand;
  // Carry out of the top bit is simply dropped; no flag, no trap
  assign sum     = first_operand + addend;

endmodule // iad_adder

// *** iad_core.sv ***
// Integer add execute stage: decodes, adds, holds one write-back result.
// Assumes decode delivers the instruction word with both operand values
// already read from the register file, and write-back accepts via wb_ready.
`timescale 1ns/100ps
module iad_core #(
  parameter int unsigned DATA_W = iad_pkg::DATA_W,
  parameter int unsigned TID_W  = iad_pkg::TID_W
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  // Issue from decode
  input  wire logic                      issue_valid,
  input  wire logic [31:0]               issue_instr,
  input  wire logic [TID_W-1:0]          issue_thread,
  input  wire logic [DATA_W-1:0]         first_source_operand,
  input  wire logic [DATA_W-1:0]         second_operand_value,
  output logic                           issue_ready,
  // Write-back to register file
  input  wire logic                      wb_ready,
  output logic                           wb_valid,
  output logic [TID_W-1:0]               wb_thread,
  output logic [iad_pkg::IDX_W-1:0]      wb_dest_idx,
  output logic [DATA_W-1:0]              wb_data,
  // Decode outcome
  output logic                           not_handled,
  output logic                           bad_operand
);

  localparam int unsigned IW = iad_pkg::IDX_W;
  localparam int unsigned MW = iad_pkg::IMM_W;

  // Decoded fields
  logic [3:0]              opcode;
  logic [5:0]              func_code;
  logic [3:0]              sub_code;
  logic [IW-1:0]           r_second_operand_field;
  logic [IW-1:0]           r_third_field_destination;
  logic [IW-1:0]           i_second_operand_field;
  logic [MW-1:0]           short_signed_immediate_field;

  iad_pkg::iad_op_t        op;
  logic [IW-1:0]           dest_idx;
  logic [DATA_W-1:0]       sum;
  logic                    take;
  logic                    add_take;
  logic                    slot_free;
  logic                    use_imm;

  // Next values of the output registers
  logic                    issue_ready_d;
  logic                    wb_valid_d;
  logic [TID_W-1:0]        wb_thread_d;
  logic [IW-1:0]           wb_dest_idx_d;
  logic [DATA_W-1:0]       wb_data_d;
  logic                    not_handled_d;
  logic                    bad_operand_d;

  // Output registers
  logic                    wb_valid_q;
  logic [TID_W-1:0]        wb_thread_q;
  logic [IW-1:0]           wb_dest_idx_q;
  logic [DATA_W-1:0]       wb_data_q;
  logic                    not_handled_q;
  logic                    bad_operand_q;
  logic                    issue_ready_q;

  // Field extraction
  assign opcode                       = issue_instr[iad_pkg::OPC_HI:iad_pkg::OPC_LO];
  assign func_code                    = issue_instr[iad_pkg::R_FN_HI:iad_pkg::R_FN_LO];
  assign sub_code                     = issue_instr[iad_pkg::I_SUB_HI:iad_pkg::I_SUB_LO];
  assign r_second_operand_field       = issue_instr[iad_pkg::R_B_LO +: IW];
  assign r_third_field_destination    = issue_instr[iad_pkg::R_C_LO +: IW];
  assign i_second_operand_field       = issue_instr[iad_pkg::I_B_LO +: IW];
  assign short_signed_immediate_field = issue_instr[iad_pkg::I_IMM_LO +: MW];

  // Instruction recognition
  always_comb begin
    op = iad_pkg::IAD_OP_NONE;
    if (opcode == iad_pkg::OPC_RTYPE && func_code == iad_pkg::FN_ADD) begin
      // Extension register as second operand is refused
      if (r_second_operand_field[iad_pkg::EXT_BIT]) begin
        op = iad_pkg::IAD_OP_BAD;
      end else begin
        op = iad_pkg::IAD_OP_ADD;
      end
    end else if (opcode == iad_pkg::OPC_ITYPE && sub_code == iad_pkg::SUB_ADDI) begin
      op = iad_pkg::IAD_OP_ADDI;
    end
  end

  // Destination field differs per form
  always_comb begin
    unique case (op)
      iad_pkg::IAD_OP_ADDI: dest_idx = i_second_operand_field;
      default:              dest_idx = r_third_field_destination;
    endcase
  end

  iad_adder #(
    .WIDTH (DATA_W),
    .IMM_W (MW)
  ) u_adder (
    .first_operand   (first_source_operand),
    .second_operand  (second_operand_value),
    .short_immediate (short_signed_immediate_field),
    .use_immediate   (use_imm),
    .sum             (sum)
  );

  // One result slot; it frees when write-back takes it
  assign slot_free = !wb_valid_q || wb_ready;
  assign take      = issue_valid && issue_ready_q;
  assign add_take  = take && (op == iad_pkg::IAD_OP_ADD || op == iad_pkg::IAD_OP_ADDI);
  assign use_imm   = (op == iad_pkg::IAD_OP_ADDI);

  // Slot occupancy; neither carry nor overflow leaves the block
  always_comb begin
    wb_valid_d = wb_valid_q;
    if (add_take) begin
      wb_valid_d = 1'b1;
    end else if (slot_free) begin
      wb_valid_d = 1'b0;
    end
  end

  // Ready only for an empty slot: a registered ready cannot know whether
  // write-back drains a held result next cycle, so an add costs one bubble
  always_comb begin
    issue_ready_d = !wb_valid_d;
  end

  // Result held until write-back takes it
  always_comb begin
    wb_data_d     = wb_data_q;
    wb_dest_idx_d = wb_dest_idx_q;
    wb_thread_d   = wb_thread_q;
    if (add_take) begin
      wb_data_d     = sum;
      wb_dest_idx_d = dest_idx;
      wb_thread_d   = issue_thread;
    end
  end

  // Per-issue decode status, one-cycle pulses
  always_comb begin
    not_handled_d = take && (op == iad_pkg::IAD_OP_NONE);
    bad_operand_d = take && (op == iad_pkg::IAD_OP_BAD);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      issue_ready_q <= 1'b0;
    end else begin
      issue_ready_q <= issue_ready_d;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_valid_q <= 1'b0;
    end else begin
      wb_valid_q <= wb_valid_d;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_data_q <= DATA_W'(iad_pkg::RST_DATA);
    end else begin
      wb_data_q <= wb_data_d;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_dest_idx_q <= iad_pkg::RST_IDX;
    end else begin
      wb_dest_idx_q <= wb_dest_idx_d;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_thread_q <= '0;
    end else begin
      wb_thread_q <= wb_thread_d;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      not_handled_q <= 1'b0;
    end else begin
      not_handled_q <= not_handled_d;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bad_operand_q <= 1'b0;
    end else begin
      bad_operand_q <= bad_operand_d;
    end
  end

  assign issue_ready = issue_ready_q;
  assign wb_valid    = wb_valid_q;
  assign wb_thread   = wb_thread_q;
  assign wb_dest_idx = wb_dest_idx_q;
  assign wb_data     = wb_data_q;
  assign not_handled = not_handled_q;
  assign bad_operand = bad_operand_q;

endmodule // iad_core

// *** iad_unused.sv ***
`timescale 1ns/100ps

// *** iad_sva.sv ***
// Port checker for the add datapath execute stage.
// Assumes it is bound to iad_core and sees only its ports.
`timescale 1ns/100ps
module iad_sva #(parameter int unsigned DATA_W = 32, parameter int unsigned TID_W = 4) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Issue
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [TID_W-1:0] issue_thread,
  input wire logic [DATA_W-1:0] first_source_operand,
  input wire logic [DATA_W-1:0] second_operand_value,
  input wire logic issue_ready,
  // Write-back and status
  input wire logic wb_ready,
  input wire logic wb_valid,
  input wire logic [TID_W-1:0] wb_thread,
  input wire logic [iad_pkg::IDX_W-1:0] wb_dest_idx,
  input wire logic [DATA_W-1:0] wb_data,
  input wire logic not_handled,
  input wire logic bad_operand
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire tk = issue_valid && issue_ready;
  wire radd = issue_instr[31:28] == 4'h3 && issue_instr[5:0] == 6'h31;
  wire iadd = issue_instr[31:28] == 4'h2 && issue_instr[15:12] == 4'h3;
  wire [5:0] c_idx = issue_instr[13:8];
  wire [5:0] b_idx = issue_instr[21:16];
  wire [11:0] imm_mag = -issue_instr[11:0];
  wire [DATA_W-1:0] rsum = first_source_operand + second_operand_value;
  wire [DATA_W-1:0] isum = first_source_operand + DATA_W'($signed(issue_instr[11:0]));
  wire both_neg = first_source_operand[DATA_W-1] && second_operand_value[DATA_W-1];
  wire ovf = (first_source_operand[DATA_W-1] == second_operand_value[DATA_W-1]) && (rsum[DATA_W-1] != first_source_operand[DATA_W-1]);
  sequence s_radd; tk && radd && !issue_instr[19]; endsequence
  sequence s_iadd; tk && iadd; endsequence
  reg_sum_a: assert property (s_radd |=> wb_valid && wb_data == $past(rsum) && wb_dest_idx == $past(c_idx))
    else $error("register add result wrong");
  ext_refuse_a: assert property (tk && radd && issue_instr[19] |=> bad_operand && !not_handled)
    else $error("extension operand not refused");
  imm_sum_a: assert property (s_iadd |=> wb_valid && wb_data == $past(isum) && wb_dest_idx == $past(b_idx))
    else $error("immediate add result wrong");
  imm_sign_a: assert property (s_iadd and issue_instr[11] |=> wb_data == $past(first_source_operand) - $past(imm_mag))
    else $error("negative immediate not sign extended");
  carry_wrap_a: assert property (s_radd and both_neg |=> wb_data < $past(first_source_operand))
    else $error("sum does not wrap");
  ovf_quiet_a: assert property (s_radd and ovf |=> wb_valid && !not_handled && !bad_operand)
    else $error("overflow disturbed result");
  decode_a: assert property (tk && !radd && !iadd |=> not_handled && !bad_operand)
    else $error("non-add word not reported");
  pulse_cause_a: assert property (!tk |=> !not_handled && !bad_operand)
    else $error("status pulse without issue");
  thread_tag_a: assert property (tk && (radd && !issue_instr[19] || iadd) |=> wb_thread == $past(issue_thread))
    else $error("thread tag not carried");
  hold_result_a: assert property (wb_valid && !wb_ready |=> wb_valid && $stable(wb_data) && $stable(wb_dest_idx) && $stable(wb_thread))
    else $error("pending result changed");
  no_overrun_a: assert property (wb_valid && !wb_ready |-> !issue_ready)
    else $error("issue accepted over pending result");
  drain_a: assert property (wb_valid && wb_ready |=> !wb_valid)
    else $error("result not released after write-back");
endmodule // iad_sva

// *** iad_wb_sink.sv ***
// Write-back side model: takes results at once or with random stalls.
// Assumes the bench seeds the random generator once.
`timescale 1ns/100ps
module iad_wb_sink (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Stall mode from the bench
  input wire logic slow,
  // Write-back handshake
  input wire logic wb_valid,
  output logic wb_ready
);
  initial wb_ready = 1'b0;
  // Ready as a level, so stalls also back up the issue side
  always @(posedge sys_clk) wb_ready <= #1 !sys_rst && (!slow || $urandom_range(2) == 0);
endmodule // iad_wb_sink

// *** testbench.sv ***
// Random register and immediate adds, near-miss words, prompt then stalled write-back.
// Assumes iad_pkg, iad_core, iad_wb_sink and iad_sva compiled first.
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 1'b0, sys_rst = 1'b1, issue_valid = 1'b0, slow = 1'b0;
  logic [31:0] issue_instr = 32'h0, first_source_operand = 32'h0, second_operand_value = 32'h0;
  logic [3:0] issue_thread = 4'h0, wb_thread;
  logic issue_ready, wb_ready, wb_valid, not_handled, bad_operand;
  logic [5:0] wb_dest_idx;
  logic [31:0] wb_data;
  logic [31:0] corner[3] = '{32'hffff_ffff, 32'h7fff_ffff, 32'h8000_0000};
  logic [43:0] exp_q[$];
  int num_errors = 0, checks_done = 0, cycles = 0;
  always #2 sys_clk = ~sys_clk;
  iad_core dut (
    .sys_clk              (sys_clk),
    .sys_rst              (sys_rst),
    .issue_valid          (issue_valid),
    .issue_instr          (issue_instr),
    .issue_thread         (issue_thread),
    .first_source_operand (first_source_operand),
    .second_operand_value (second_operand_value),
    .issue_ready          (issue_ready),
    .wb_ready             (wb_ready),
    .wb_valid             (wb_valid),
    .wb_thread            (wb_thread),
    .wb_dest_idx          (wb_dest_idx),
    .wb_data              (wb_data),
    .not_handled          (not_handled),
    .bad_operand          (bad_operand)
  );
  iad_wb_sink sink (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .slow     (slow),
    .wb_valid (wb_valid),
    .wb_ready (wb_ready)
  );
  task automatic close_out();
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [43:0] g);
    checks_done++;
    if (exp_q.size() == 0 || g !== exp_q[0]) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h", $time, g);
    end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  endtask
  // Held across calls, so consecutive issues go back to back except while each add's result waits for write-back
  task automatic issue(input logic [31:0] w, a, b, input logic [43:0] e);
    logic rdy;
    issue_valid = 1'b1;
    issue_instr = w;
    first_source_operand = a;
    second_operand_value = b;
    issue_thread = a[3:0];
    do begin
      @(negedge sys_clk) rdy = issue_ready;
      @(posedge sys_clk);
    end while (rdy !== 1'b1);
    exp_q.push_back(e);
    #1;
  endtask
  always @(negedge sys_clk) if (!sys_rst) begin
    if (wb_valid === 1'b1 && wb_ready === 1'b1) check({2'd0, wb_thread, wb_dest_idx, wb_data});
    if (not_handled === 1'b1) check({2'd1, 42'h0});
    if (bad_operand === 1'b1) check({2'd2, 42'h0});
  end
  always @(posedge sys_clk) if (++cycles == 8000) begin
    num_errors++;
    close_out();
  end
  initial begin
    logic [31:0] w, a, b;
    void'($urandom(32'hdaad));
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    for (int n = 0; n < 400; n++) begin
      slow = n >= 200;
      w = $urandom;
      a = $urandom_range(3) == 3 ? $urandom : corner[$urandom_range(2)];
      b = $urandom_range(3) == 3 ? $urandom : corner[$urandom_range(2)];
      case ($urandom_range(2))
        0: begin
          w[31:28] = 4'h3;
          w[5:0] = 6'h31;
          issue(w, a, b, w[19] ? {2'd2, 42'h0} : {2'd0, a[3:0], w[13:8], a + b});
        end
        1: begin
          w[31:28] = 4'h2;
          w[15:12] = 4'h3;
          issue(w, a, b, {2'd0, a[3:0], w[21:16], a + {{20{w[11]}}, w[11:0]}});
        end
        default: begin
          w[31:28] = w[0] ? 4'h3 : 4'h2;
          w[5:0] = 6'h30;
          w[15:12] = 4'h4;
          issue(w, a, b, {2'd1, 42'h0});
        end
      endcase
    end
    issue_valid = 1'b0;
    repeat (40) @(posedge sys_clk);
    checks_done++;
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("CHECK FAILED %0t results missing", $time);
    end
    close_out();
  end
endmodule // testbench
bind iad_core iad_sva #(.DATA_W(DATA_W), .TID_W(TID_W)) chk (
  .sys_clk              (sys_clk),
  .sys_rst              (sys_rst),
  .issue_valid          (issue_valid),
  .issue_instr          (issue_instr),
  .issue_thread         (issue_thread),
  .first_source_operand (first_source_operand),
  .second_operand_value (second_operand_value),
  .issue_ready          (issue_ready),
  .wb_ready             (wb_ready),
  .wb_valid             (wb_valid),
  .wb_thread            (wb_thread),
  .wb_dest_idx          (wb_dest_idx),
  .wb_data              (wb_data),
  .not_handled          (not_handled),
  .bad_operand          (bad_operand)
);
